//--- rtl/swe_pkg.sv
// package for the standby wake-up enable upper byte block
package swe_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] SWE_ADDR_ENABLE = 12'h000;
  localparam logic [11:0] SWE_ADDR_STATUS = 12'h004;
  localparam logic [11:0] SWE_ADDR_MASK   = 12'h008;
  localparam logic [11:0] SWE_ADDR_RAW    = 12'h00C;

  // ==========================================================================
  // field positions within the enable register
  localparam int SWE_LSB          = 24;
  localparam int SWE_NSRC         = 8;
  localparam int SWE_BIT_RTC_ALM  = 24;
  localparam int SWE_BIT_RTC_PRD  = 25;
  localparam int SWE_BIT_RSVD     = 26;
  localparam int SWE_BIT_USB      = 27;
  localparam int SWE_BIT_LPT_UDF  = 28;
  localparam int SWE_BIT_LPT_CMA  = 29;
  localparam int SWE_BIT_LPT_CMB  = 30;
  localparam int SWE_BIT_I2C      = 31;

  // writable bits of the upper byte, reserved bit 26 excluded
  localparam logic [7:0]  SWE_WMASK      = 8'hFB;
  localparam logic [7:0]  SWE_RESET_EN   = 8'h00;
  localparam logic [7:0]  SWE_RESET_MASK = 8'h00;
  localparam logic [31:0] SWE_RDATA_ZERO = 32'h00000000;

  // ==========================================================================
  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } swe_apb_req_type;

  typedef enum logic [1:0] {
    SWE_ST_RUN   = 2'b01,
    SWE_ST_SBY   = 2'b10
  } swe_state_type;

endpackage

//--- rtl/swe_sync_gate.sv
// per-source wake gating: enable qualifies each interrupt line
`timescale 1ns/1ps
module swe_sync_gate
  import swe_pkg::*;
(
  // clock and reset
  input  wire logic                MCLK_I,
  input  wire logic                NRST_I,
  // sources and enables
  input  wire logic [SWE_NSRC-1:0] irq_i,
  input  wire logic [SWE_NSRC-1:0] en_i,
  // gated wake requests
  output logic      [SWE_NSRC-1:0] wake_o
);

  logic [SWE_NSRC-1:0] wake_d;
  logic [SWE_NSRC-1:0] wake_q;

  // ==========================================================================
  // gating, one bit per source
  genvar g;
  generate
    for (g = 0; g < SWE_NSRC; g++) begin : g_src
      // (R5) per-source gating
      always_comb begin
        wake_d[g] = irq_i[g] & en_i[g];
      end
    end
  endgenerate

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      wake_q <= '0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign wake_o = wake_q;

endmodule

//--- rtl/swe_top.sv
// standby wake-up enable register, upper byte, with standby exit logic
`timescale 1ns/1ps

// Overview of operation
// (R1) rtc period wakes only when enabled
// (R2) reserved bit 26 always reads zero
// (R3) usb full-speed wake gated by enable
// (R4) timer match a wakes only when enabled
// (R5) other bits gate their own sources
module swe_top
  import swe_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        NRST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // peripheral interrupt lines, bit n maps to enable bit 24+n
  input  wire logic [7:0]  SRC_IRQ_I,
  // standby control
  input  wire logic        STANDBY_REQ_I,
  output logic             STANDBY_O,
  output logic             WAKE_O,
  // interrupt
  output logic             IRQ_O
);

  // ==========================================================================
  // state
  swe_apb_req_type req;
  logic            access;
  logic            complete;
  logic            wr_done;
  logic            rd_start;
  logic            ready_q,  ready_d;
  logic            err_q,    err_d;
  logic [31:0]     rdata_q,  rdata_d;
  logic [7:0]      en_q,     en_d;
  logic [7:0]      msk_q,    msk_d;
  logic [7:0]      sts_q,    sts_d;
  logic            irq_q,    irq_d;
  logic            wake_q,   wake_d;
  swe_state_type   st_q,     st_d;
  logic [7:0]      gate_en;
  logic [7:0]      wake_src;

  // ==========================================================================
  // named enable bits, one per wake source
  logic            rtc_alarm_wake_en;
  logic            rtc_periodic_wake_en;
  logic            usb_fullspeed_wake_en;
  logic            lp_timer_underflow_wake_en;
  logic            lp_timer_match_a_wake_en;
  logic            lp_timer_match_b_wake_en;
  logic            i2c_addr_match_wake_en;

  assign req.sel    = PSEL_I;
  assign req.enable = PENABLE_I;
  assign req.write  = PWRITE_I;
  assign req.addr   = PADDR_I;
  assign req.wdata  = PWDATA_I;

  // ==========================================================================
  // decode helpers
  // position of a named enable within the stored upper byte
  function automatic int en_idx(input int bit_pos);
    en_idx = bit_pos - SWE_LSB;
  endfunction

  function automatic logic hit_enable(input logic [11:0] a);
    hit_enable = (a == SWE_ADDR_ENABLE);
  endfunction

  function automatic logic hit_status(input logic [11:0] a);
    hit_status = (a == SWE_ADDR_STATUS);
  endfunction

  function automatic logic hit_mask(input logic [11:0] a);
    hit_mask = (a == SWE_ADDR_MASK);
  endfunction

  function automatic logic hit_raw(input logic [11:0] a);
    hit_raw = (a == SWE_ADDR_RAW);
  endfunction

  // address decode that sets the slave error on both reads and writes
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = hit_enable(a) || hit_status(a) || hit_mask(a) || hit_raw(a);
  endfunction

  // enable byte back in its place at the top of the word
  function automatic logic [31:0] place_enable(input logic [7:0] e);
    logic [31:0] w;
    w                      = SWE_RDATA_ZERO;
    w[SWE_LSB +: SWE_NSRC] = e & SWE_WMASK;
    place_enable           = w;
  endfunction

  // status, mask and raw registers sit in the low byte
  function automatic logic [31:0] place_low(input logic [7:0] v);
    logic [31:0] w;
    w         = SWE_RDATA_ZERO;
    w[7:0]    = v;
    place_low = w;
  endfunction

  // ==========================================================================
  // apb handshake
  // one wait state: the answer comes in the second access cycle, and a
  // write lands only at the edge that completes the transfer
  always_comb begin
    access   = req.sel && req.enable && !ready_q;
    complete = req.sel && req.enable && ready_q;
    wr_done  = complete && req.write;
    rd_start = access && !req.write;
    ready_d  = access;
    err_d    = access && !addr_ok(req.addr);
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  // ==========================================================================
  // enable register
  always_comb begin
    en_d = en_q;
    if (wr_done && hit_enable(req.addr)) begin
      // (R2) reserved bit never stored
      en_d = req.wdata[SWE_LSB +: SWE_NSRC] & SWE_WMASK;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      en_q <= SWE_RESET_EN;
    end else begin
      en_q <= en_d;
    end
  end

  // (R5) alarm enable, every bit but reserved bit 26 read/write
  assign rtc_alarm_wake_en          = en_q[en_idx(SWE_BIT_RTC_ALM)];
  // (R1) rtc period enable
  assign rtc_periodic_wake_en       = en_q[en_idx(SWE_BIT_RTC_PRD)];
  // (R3) usb full-speed enable
  assign usb_fullspeed_wake_en      = en_q[en_idx(SWE_BIT_USB)];
  // (R5) timer underflow enable
  assign lp_timer_underflow_wake_en = en_q[en_idx(SWE_BIT_LPT_UDF)];
  // (R4) timer match a enable
  assign lp_timer_match_a_wake_en   = en_q[en_idx(SWE_BIT_LPT_CMA)];
  // (R5) match b and i2c enables
  assign lp_timer_match_b_wake_en   = en_q[en_idx(SWE_BIT_LPT_CMB)];
  assign i2c_addr_match_wake_en     = en_q[en_idx(SWE_BIT_I2C)];

  // ==========================================================================
  // wake gating
  always_comb begin
    gate_en                          = 8'h00;
    gate_en[en_idx(SWE_BIT_RTC_ALM)] = rtc_alarm_wake_en;
    gate_en[en_idx(SWE_BIT_RTC_PRD)] = rtc_periodic_wake_en;
    // (R2) reserved source never wakes
    gate_en[en_idx(SWE_BIT_RSVD)]    = 1'b0;
    gate_en[en_idx(SWE_BIT_USB)]     = usb_fullspeed_wake_en;
    gate_en[en_idx(SWE_BIT_LPT_UDF)] = lp_timer_underflow_wake_en;
    gate_en[en_idx(SWE_BIT_LPT_CMA)] = lp_timer_match_a_wake_en;
    gate_en[en_idx(SWE_BIT_LPT_CMB)] = lp_timer_match_b_wake_en;
    gate_en[en_idx(SWE_BIT_I2C)]     = i2c_addr_match_wake_en;
  end

  swe_sync_gate u_gate (
    .MCLK_I (MCLK_I),
    .NRST_I (NRST_I),
    .irq_i  (SRC_IRQ_I),
    .en_i   (gate_en),
    .wake_o (wake_src)
  );

  // ==========================================================================
  // mask register
  always_comb begin
    msk_d = msk_q;
    if (wr_done && hit_mask(req.addr)) begin
      msk_d = req.wdata[7:0] & SWE_WMASK;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      msk_q <= SWE_RESET_MASK;
    end else begin
      msk_q <= msk_d;
    end
  end

  // ==========================================================================
  // status register, sticky, write one to clear
  always_comb begin
    sts_d = sts_q;
    if (wr_done && hit_status(req.addr)) begin
      sts_d = sts_q & ~req.wdata[7:0];
    end
    // set wins over a write-one clear in the same cycle, so no event is lost
    sts_d = sts_d | wake_src;
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      sts_q <= 8'h00;
    end else begin
      sts_q <= sts_d;
    end
  end

  // ==========================================================================
  // interrupt output
  always_comb begin
    irq_d = |(sts_d & msk_d);
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // read data, held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd_start) begin
      if (hit_enable(req.addr)) begin
        // (R2) reserved bit reads zero
        rdata_d = place_enable(en_q);
      end else if (hit_status(req.addr)) begin
        rdata_d = place_low(sts_q);
      end else if (hit_mask(req.addr)) begin
        rdata_d = place_low(msk_q);
      end else if (hit_raw(req.addr)) begin
        rdata_d = place_low(SRC_IRQ_I);
      end else begin
        rdata_d = SWE_RDATA_ZERO;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      rdata_q <= SWE_RDATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // standby exit
  always_comb begin
    st_d   = st_q;
    wake_d = 1'b0;
    case (st_q)
      SWE_ST_RUN: begin
        if (STANDBY_REQ_I) begin
          st_d = SWE_ST_SBY;
        end
      end
      SWE_ST_SBY: begin
        // (R1) (R3) (R4) only enabled sources end standby
        if (|wake_src) begin
          st_d   = SWE_ST_RUN;
          wake_d = 1'b1;
        end
      end
      default: st_d = SWE_ST_RUN;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      st_q   <= SWE_ST_RUN;
      wake_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      wake_q <= wake_d;
    end
  end

  // ==========================================================================
  // outputs, each straight from its register
  assign PRDATA_O  = rdata_q;
  assign PREADY_O  = ready_q;
  assign PSLVERR_O = err_q;
  assign IRQ_O     = irq_q;
  assign WAKE_O    = wake_q;
  assign STANDBY_O = st_q[1];

endmodule

//--- bench/swe_chk.sv
// assertions for the standby wake-up enable block
`timescale 1ns/1ps
module swe_chk
  import swe_pkg::*;
(
  // clock, reset, apb
  input wire logic        MCLK_I,
  input wire logic        NRST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  // wake path
  input wire logic [7:0]  SRC_IRQ_I,
  input wire logic        STANDBY_O,
  input wire logic        WAKE_O
);
  logic [7:0] en_d;
  logic [7:0] en_q;
  logic       acc;
  // ==========
  // shadow enable register, bit 26 never stored
  assign acc = PSEL_I & PENABLE_I & PREADY_O & (PADDR_I == SWE_ADDR_ENABLE);
  always_comb en_d = (acc & PWRITE_I) ? PWDATA_I[31:24] & SWE_WMASK : en_q;
  always_ff @(posedge MCLK_I) en_q <= NRST_I ? en_d : 8'h00;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  AST_RSVD: assert property (acc & !PWRITE_I |-> !PRDATA_O[26])
    else $error("reserved bit read as one");
  AST_RDBK: assert property (acc & !PWRITE_I |-> PRDATA_O == {en_q, 24'h000000})
    else $error("enable readback wrong");
  AST_PRD: assert property (STANDBY_O & SRC_IRQ_I[1] & en_q[1] |-> ##[1:3] WAKE_O)
    else $error("period source did not wake");
  AST_USB: assert property (STANDBY_O & SRC_IRQ_I[3] & en_q[3] |-> ##[1:3] WAKE_O)
    else $error("usb source did not wake");
  AST_CMA: assert property (STANDBY_O & SRC_IRQ_I[5] & en_q[5] |-> ##[1:3] WAKE_O)
    else $error("match a source did not wake");
  AST_GATE: assert property (WAKE_O |-> |(en_q & ($past(SRC_IRQ_I) | $past(SRC_IRQ_I, 2))))
    else $error("wake without an enabled source");
  AST_EXIT: assert property (WAKE_O |-> !STANDBY_O && $past(STANDBY_O))
    else $error("wake did not end standby");
  cover property (WAKE_O);
  cover property (acc & !PWRITE_I);
  cover property (STANDBY_O ##1 !STANDBY_O);
endmodule
bind swe_top swe_chk u_chk (.*);

//--- bench/swe_src_model.sv
// peripheral interrupt sources feeding the wake logic
`timescale 1ns/1ps
module swe_src_model (
  // clock and interrupt lines
  input  wire logic       MCLK_I,
  output logic      [7:0] SRC_IRQ_I
);
  initial SRC_IRQ_I = 8'h00;
  task automatic fire(input logic [7:0] m);
    @(posedge MCLK_I);
    SRC_IRQ_I <= m;
    @(posedge MCLK_I);
    SRC_IRQ_I <= 8'h00;
  endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the wake-up enable block
`timescale 1ns/1ps
module tb_top
  import swe_pkg::*;
;
  logic        MCLK_I = 1'h0, NRST_I = 1'h0, PSEL_I = 1'h0, PENABLE_I = 1'h0;
  logic        PWRITE_I = 1'h0, STANDBY_REQ_I = 1'h0, err, PREADY_O, PSLVERR_O;
  logic        STANDBY_O, WAKE_O, IRQ_O;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
  logic [7:0]  SRC_IRQ_I;
  int          fail_count = 0, n_checks = 0, k;
  swe_top u_dut (.*);
  swe_src_model u_src (.*);
  always #2.5 MCLK_I = ~MCLK_I;
  // ==========
  // check and bus tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge MCLK_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'h2, w, a, d};
    @(posedge MCLK_I);
    PENABLE_I <= 1'h1;
    do begin
      @(posedge MCLK_I);
      t++;
    end while (PREADY_O !== 1'h1 && t < 20);
    rd = PRDATA_O;
    err = PSLVERR_O;
    {PSEL_I, PENABLE_I} <= 2'h0;
    if (t >= 20) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge MCLK_I);
    NRST_I <= 1'h1;
    apb(1'h0, SWE_ADDR_ENABLE, 32'h0);
    chk("enable reset", rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped read", rd, 32'h0);
    apb(1'h1, SWE_ADDR_ENABLE, 32'hFFFFFFFF);
    apb(1'h0, SWE_ADDR_ENABLE, 32'h0);
    chk("enable all", rd, 32'hFB000000);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, SWE_ADDR_ENABLE, 32'h1 << (24 + i));
      apb(1'h0, SWE_ADDR_ENABLE, 32'h0);
      chk("enable one", rd, (i == 2) ? 32'h0 : 32'h1 << (24 + i));
      @(posedge MCLK_I);
      STANDBY_REQ_I <= 1'h1;
      @(posedge MCLK_I);
      STANDBY_REQ_I <= 1'h0;
      u_src.fire(8'hFF ^ (8'h1 << i));
      repeat (4) @(posedge MCLK_I);
      chk("blocked", {31'h0, STANDBY_O}, 32'h1);
      u_src.fire(8'h1 << i);
      // the reserved source must leave standby alone, so this window may run out
      for (k = 0; k < 8 && WAKE_O !== 1'h1; k++) @(posedge MCLK_I);
      chk("woken", {31'h0, k < 8}, {31'h0, i != 2});
    end
    apb(1'h0, SWE_ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h000000FB);
    chk("irq masked", {31'h0, IRQ_O}, 32'h0);
    apb(1'h1, SWE_ADDR_MASK, 32'h000000FF);
    repeat (2) @(posedge MCLK_I);
    chk("irq on", {31'h0, IRQ_O}, 32'h1);
    apb(1'h0, SWE_ADDR_MASK, 32'h0);
    chk("mask", rd, {24'h0, SWE_WMASK});
    apb(1'h0, SWE_ADDR_RAW, 32'h0);
    chk("raw idle", rd, 32'h0);
    apb(1'h1, SWE_ADDR_STATUS, 32'h0000007B);
    apb(1'h0, SWE_ADDR_STATUS, 32'h0);
    chk("status w1c", rd, 32'h00000080);
    apb(1'h1, SWE_ADDR_STATUS, 32'h00000080);
    repeat (2) @(posedge MCLK_I);
    chk("irq off", {31'h0, IRQ_O}, 32'h0);
    print_verdict();
  end
endmodule
